// ---- design/sam_top.sv ----
// Spectrum acquisition and bank-switched spectrum memory
// Contract
// RULE1: Four channels each keep their own energy histogram.
// RULE2: Each channel takes 14-bit samples at 50 MHz as its pulse source.
// RULE3: Spectrum length is set between 256 and 16384 bins in either mode.
// RULE4: Single mode builds one spectrum per channel with statistics in 32-bit bins.
// RULE5: Single mode runs start and stop by command or on preset real, live, input or output count.
// RULE6: Single mode clears memory at start unless preservation is selected.
// RULE7: Single mode memory is readable by the host during and after a run.
// RULE8: All channels halt while the external gate is low.
// RULE9: Start and stop are shared among cards over the module sync line.
// RULE10: Mapping mode makes a spectrum sequence and advances on the timing signal.
// RULE11: Mapping runs start and stop by command or after a preset spectrum count.
// RULE12: Mapping bins are 16-bit counters.
// RULE13: Mapping memory is two banks, each owned by either host or DSP only.
// RULE14: The DSP fills one bank while the host reads the other, then they swap.
// RULE15: The external logic input may be chosen as the pixel advance source.
// RULE16: A full bin saturates instead of wrapping.
// RULE17: Banks swap only after host release and a full DSP bank, flagging each swap.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module sam_top (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [sam_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [sam_pkg::NUM_CH-1:0] evt_valid,
	input wire logic [sam_pkg::NUM_CH*sam_pkg::SAMPLE_W-1:0] evt_energy,
	input wire logic [sam_pkg::NUM_CH-1:0] evt_seen,
	input wire logic [sam_pkg::NUM_CH-1:0] live_tick,
	input wire logic gate_in,
	input wire logic ext_logic_in,
	input wire logic pixel_sw,
	input wire logic module_sync_line_i,
	output logic module_sync_line_o,
	output logic module_sync_line_oe,
	output logic [sam_pkg::NUM_CH-1:0] evt_ready,
	output logic running
);
	localparam int N = sam_pkg::NUM_CH;
	localparam int SW = sam_pkg::SAMPLE_W;
	localparam int AW = sam_pkg::BIN_AW;
	localparam int MW = sam_pkg::CH_W + AW;
	logic [1:0] rst_sync_q;
	logic rst_n;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];
	// Two-stage synchronisers for pin inputs
	logic [3:0] s1_q, s2_q, s3_q;
	logic gate_s, ext_s, pix_s, sync_s, ext_rise, sync_rise, sync_fall;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			// Sync line idles high while held in reset
			s1_q <= 4'h8;
			s2_q <= 4'h8;
			s3_q <= 4'h8;
		end else begin
			s1_q <= {module_sync_line_i, pixel_sw, ext_logic_in, gate_in};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign gate_s = s2_q[0];
	assign ext_s = s2_q[1];
	assign pix_s = s2_q[2];
	assign sync_s = s2_q[3];
	assign ext_rise = s2_q[1] && !s3_q[1];
	assign sync_rise = s2_q[3] && !s3_q[3];
	assign sync_fall = !s2_q[3] && s3_q[3];
	// Registers
	logic [15:0] ctrl_q, ctrl_d;
	logic [15:0] nbins_q, nbins_d;
	logic [31:0] pre_real_q, pre_real_d, pre_live_q, pre_live_d;
	logic [31:0] pre_in_q, pre_in_d, pre_out_q, pre_out_d, pre_pix_q, pre_pix_d;
	logic [MW:0] mem_addr_q, mem_addr_d;
	logic [31:0] rdata_q, rdata_d;
	logic wr_ctrl, start_cmd, stop_cmd, host_done;
	always_comb begin
		ctrl_d = ctrl_q;
		nbins_d = nbins_q;
		pre_real_d = pre_real_q;
		pre_live_d = pre_live_q;
		pre_in_d = pre_in_q;
		pre_out_d = pre_out_q;
		pre_pix_d = pre_pix_q;
		mem_addr_d = mem_addr_q;
		wr_ctrl = reg_wr && reg_addr == sam_pkg::REG_CTRL;
		start_cmd = wr_ctrl && reg_wdata[sam_pkg::CTRL_START];
		stop_cmd = wr_ctrl && reg_wdata[sam_pkg::CTRL_STOP];
		host_done = reg_wr && reg_addr == sam_pkg::REG_HOST_DONE && reg_wdata[0];
		if (reg_wr) begin
			case (reg_addr)
				sam_pkg::REG_CTRL: ctrl_d = {reg_wdata[15:2], 2'h0};
				// RULE3 bin count range
				sam_pkg::REG_NBINS: begin
					if (reg_wdata[15:0] < 16'(sam_pkg::MIN_BINS)) begin
						nbins_d = 16'(sam_pkg::MIN_BINS);
					end else if (reg_wdata[15:0] > 16'(sam_pkg::MAX_BINS)) begin
						nbins_d = 16'(sam_pkg::MAX_BINS);
					end else begin
						nbins_d = reg_wdata[15:0];
					end
				end
				sam_pkg::REG_PRESET_REAL: pre_real_d = reg_wdata;
				sam_pkg::REG_PRESET_LIVE: pre_live_d = reg_wdata;
				sam_pkg::REG_PRESET_IN: pre_in_d = reg_wdata;
				sam_pkg::REG_PRESET_OUT: pre_out_d = reg_wdata;
				sam_pkg::REG_PRESET_PIX: pre_pix_d = reg_wdata;
				sam_pkg::REG_MEM_ADDR: mem_addr_d = reg_wdata[MW:0];
				default: begin
				end
			endcase
		end else if (reg_rd && reg_addr == sam_pkg::REG_MEM_DATA) begin
			mem_addr_d = mem_addr_q + 1'b1;
		end
	end
	// Event path: per-channel FIFO, merged round robin
	logic [N-1:0] f_valid, f_ready;
	logic [MW-1:0] f_data [N];
	logic [sam_pkg::CH_W-1:0] rr_q, rr_d;
	logic acq_en, hit, clr_busy;
	logic [AW-1:0] hit_bin;
	logic [sam_pkg::CH_W-1:0] hit_ch;
	genvar gi;
	generate
		// RULE1 per-channel path
		for (gi = 0; gi < N; gi++) begin : g_ch
			logic [SW-1:0] en;
			logic [AW-1:0] bin;
			logic [MW-1:0] word;
			// RULE2 14-bit energy
			assign en = evt_energy[gi*SW +: SW];
			assign bin = {2'h0, en[SW-1 -: AW]} >= nbins_q ? AW'(nbins_q - 1'b1) : en[SW-1 -: AW];
			assign word = {sam_pkg::CH_W'(gi), bin};
			sam_fifo #(.WIDTH(MW), .DEPTH(sam_pkg::FIFO_DEPTH)) u_fifo (
				.clk(core_clk),
				.rst_n(rst_n),
				.in_valid(evt_valid[gi] && acq_en),
				.in_ready(f_ready[gi]),
				.in_data(word),
				.out_valid(f_valid[gi]),
				.out_ready(rr_q == sam_pkg::CH_W'(gi) && !clr_busy),
				.out_data(f_data[gi])
			);
		end
	endgenerate
	always_comb begin
		rr_d = rr_q + 1'b1;
		hit = f_valid[rr_q] && !clr_busy;
		hit_bin = f_data[rr_q][AW-1:0];
		hit_ch = f_data[rr_q][MW-1:AW];
	end
	// Run control
	sam_pkg::sam_state_t st_q, st_d;
	logic [31:0] real_q, real_d, live_q, live_d, in_q, in_d, out_q, out_d, pix_q, pix_d;
	logic [MW-1:0] clr_q, clr_d;
	logic bank_q, bank_d, swap_q, swap_d, rel_q, rel_d, full_q, full_d;
	logic sync_o_q, sync_o_d, preset_hit, pix_adv, map_mode;
	logic [AW-1:0] pbin_q, pbin_d;
	always_comb begin
		st_d = st_q;
		real_d = real_q;
		live_d = live_q;
		in_d = in_q;
		out_d = out_q;
		pix_d = pix_q;
		clr_d = clr_q;
		bank_d = bank_q;
		rel_d = rel_q || host_done;
		full_d = full_q;
		sync_o_d = sync_o_q;
		swap_d = swap_q;
		pbin_d = pbin_q;
		map_mode = ctrl_q[sam_pkg::CTRL_MAP];
		// RULE15 pixel source select
		pix_adv = ctrl_q[sam_pkg::CTRL_PIX_EXT] ? ext_rise : (pix_s && !s3_q[2]);
		// RULE5 preset stop
		preset_hit = !map_mode && (
			(ctrl_q[sam_pkg::CTRL_EN_REAL] && real_q >= pre_real_q) ||
			(ctrl_q[sam_pkg::CTRL_EN_LIVE] && live_q >= pre_live_q) ||
			(ctrl_q[sam_pkg::CTRL_EN_IN] && in_q >= pre_in_q) ||
			(ctrl_q[sam_pkg::CTRL_EN_OUT] && out_q >= pre_out_q));
		// RULE11 spectrum count stop
		if (map_mode && ctrl_q[sam_pkg::CTRL_EN_PIX] && pix_q >= pre_pix_q) begin
			preset_hit = 1'b1;
		end
		case (st_q)
			sam_pkg::SAM_IDLE: begin
				// RULE9 shared start
				if (start_cmd || sync_rise) begin
					sync_o_d = 1'b1;
					real_d = '0;
					live_d = '0;
					in_d = '0;
					out_d = '0;
					pix_d = '0;
					pbin_d = '0;
					full_d = 1'b0;
					clr_d = '0;
					// RULE6 clear or preserve
					st_d = ctrl_d[sam_pkg::CTRL_PRESERVE] && !ctrl_d[sam_pkg::CTRL_MAP] ?
						sam_pkg::SAM_RUN : sam_pkg::SAM_CLEAR;
				end
			end
			sam_pkg::SAM_CLEAR: begin
				clr_d = clr_q + 1'b1;
				// Sweep only the configured bins of each channel
				// Bins above the spectrum length keep old contents
				if (clr_q[AW-1:0] == AW'(nbins_q - 1'b1)) begin
					clr_d = {sam_pkg::CH_W'(clr_q[MW-1:AW] + 1'b1), {AW{1'b0}}};
					if (&clr_q[MW-1:AW]) begin
						st_d = sam_pkg::SAM_RUN;
					end
				end
			end
			sam_pkg::SAM_RUN: begin
				// RULE9 shared stop
				if (stop_cmd || preset_hit || sync_fall) begin
					sync_o_d = 1'b0;
					st_d = sam_pkg::SAM_IDLE;
				end else begin
					// RULE8 gate halts counting
					if (gate_s) begin
						real_d = real_q + 1'b1;
						live_d = live_q + 32'($countones(live_tick));
						in_d = in_q + 32'($countones(evt_seen));
						out_d = out_q + 32'($countones(evt_valid & f_ready));
					end
					// RULE10 advance spectrum
					if (map_mode && pix_adv) begin
						pix_d = pix_q + 1'b1;
						full_d = 1'b1;
					end
				end
			end
			default: st_d = sam_pkg::SAM_IDLE;
		endcase
		// RULE17 swap on release and full
		if (map_mode && rel_q && full_q) begin
			bank_d = !bank_q;
			rel_d = host_done;
			full_d = 1'b0;
			swap_d = 1'b1;
		end else if (reg_rd && reg_addr == sam_pkg::REG_STATUS) begin
			swap_d = 1'b0;
		end
	end
	assign acq_en = st_q == sam_pkg::SAM_RUN && st_d == sam_pkg::SAM_RUN && gate_s;
	assign clr_busy = st_q == sam_pkg::SAM_CLEAR;
	// Spectrum memories
	logic [31:0] mem_s [N * sam_pkg::MAX_BINS];
	logic [15:0] mem_a [N * sam_pkg::MAX_BINS];
	logic [15:0] mem_b [N * sam_pkg::MAX_BINS];
	logic [31:0] old_s;
	logic [15:0] old_m;
	logic [MW-1:0] hit_addr;
	assign hit_addr = {hit_ch, hit_bin};
	assign old_s = mem_s[hit_addr];
	// RULE13 DSP side is the bank not owned by host
	assign old_m = bank_q ? mem_a[hit_addr] : mem_b[hit_addr];
	always_ff @(posedge core_clk) begin
		if (clr_busy) begin
			mem_s[clr_q] <= '0;
			mem_a[clr_q] <= '0;
			mem_b[clr_q] <= '0;
		end else if (hit && !map_mode) begin
			// RULE4 32-bit bins
			// RULE16 saturate
			mem_s[hit_addr] <= old_s == sam_pkg::SINGLE_MAX ? old_s : old_s + 1'b1;
		end else if (hit) begin
			// RULE12 16-bit bins
			// RULE14 DSP fills its own bank
			if (bank_q) begin
				mem_a[hit_addr] <= old_m == sam_pkg::MAP_MAX ? old_m : old_m + 1'b1;
			end else begin
				mem_b[hit_addr] <= old_m == sam_pkg::MAP_MAX ? old_m : old_m + 1'b1;
			end
		end
	end
	// Read mux
	always_comb begin
		rdata_d = 32'h0;
		if (reg_rd) begin
			case (reg_addr)
				sam_pkg::REG_CTRL: rdata_d = {16'h0, ctrl_q};
				sam_pkg::REG_NBINS: rdata_d = {16'h0, nbins_q};
				sam_pkg::REG_PRESET_REAL: rdata_d = pre_real_q;
				sam_pkg::REG_PRESET_LIVE: rdata_d = pre_live_q;
				sam_pkg::REG_PRESET_IN: rdata_d = pre_in_q;
				sam_pkg::REG_PRESET_OUT: rdata_d = pre_out_q;
				sam_pkg::REG_PRESET_PIX: rdata_d = pre_pix_q;
				sam_pkg::REG_STATUS: rdata_d = {27'h0, full_q, swap_q, !bank_q,
					clr_busy, st_q != sam_pkg::SAM_IDLE};
				sam_pkg::REG_REAL: rdata_d = real_q;
				sam_pkg::REG_LIVE: rdata_d = live_q;
				sam_pkg::REG_IN: rdata_d = in_q;
				sam_pkg::REG_OUT: rdata_d = out_q;
				sam_pkg::REG_PIX: rdata_d = pix_q;
				sam_pkg::REG_MEM_ADDR: rdata_d = 32'(mem_addr_q);
				// RULE7 host reads any time
				// RULE13 host sees only its own bank
				sam_pkg::REG_MEM_DATA: rdata_d = !map_mode ? mem_s[mem_addr_q[MW-1:0]] :
					{16'h0, bank_q ? mem_b[mem_addr_q[MW-1:0]] : mem_a[mem_addr_q[MW-1:0]]};
				default: rdata_d = 32'h0;
			endcase
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= '0;
			nbins_q <= sam_pkg::NBINS_RESET;
			pre_real_q <= '0;
			pre_live_q <= '0;
			pre_in_q <= '0;
			pre_out_q <= '0;
			pre_pix_q <= '0;
			mem_addr_q <= '0;
			rdata_q <= '0;
			rr_q <= '0;
			st_q <= sam_pkg::SAM_IDLE;
			real_q <= '0;
			live_q <= '0;
			in_q <= '0;
			out_q <= '0;
			pix_q <= '0;
			clr_q <= '0;
			bank_q <= 1'b0;
			swap_q <= 1'b0;
			rel_q <= 1'b0;
			full_q <= 1'b0;
			sync_o_q <= 1'b0;
			pbin_q <= '0;
			module_sync_line_o <= 1'b0;
			module_sync_line_oe <= 1'b0;
			evt_ready <= '0;
			running <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			nbins_q <= nbins_d;
			pre_real_q <= pre_real_d;
			pre_live_q <= pre_live_d;
			pre_in_q <= pre_in_d;
			pre_out_q <= pre_out_d;
			pre_pix_q <= pre_pix_d;
			mem_addr_q <= mem_addr_d;
			rdata_q <= rdata_d;
			rr_q <= rr_d;
			st_q <= st_d;
			real_q <= real_d;
			live_q <= live_d;
			in_q <= in_d;
			out_q <= out_d;
			pix_q <= pix_d;
			clr_q <= clr_d;
			bank_q <= bank_d;
			swap_q <= swap_d;
			rel_q <= rel_d;
			full_q <= full_d;
			sync_o_q <= sync_o_d;
			pbin_q <= pbin_d;
			module_sync_line_o <= 1'b0;
			module_sync_line_oe <= !sync_o_d;
			evt_ready <= f_ready;
			running <= st_d != sam_pkg::SAM_IDLE;
		end
	end
	assign reg_rdata = rdata_q;
endmodule : sam_top

// ---- design/sam_pkg.sv ----
// Constants for the spectrum acquisition memory block
package sam_pkg;
	localparam int NUM_CH = 4;
	localparam int SAMPLE_W = 14;
	localparam int SAMPLE_MHZ = 50;
	localparam int MIN_BINS = 256;
	localparam int MAX_BINS = 16384;
	localparam int BIN_AW = 14;
	localparam int CH_W = 2;
	localparam int ADDR_W = 8;
	localparam int FIFO_DEPTH = 32;
	localparam int EVT_W = CH_W + BIN_AW;
	localparam logic [31:0] SINGLE_MAX = 32'hFFFFFFFF;
	localparam logic [15:0] MAP_MAX = 16'hFFFF;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_NBINS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_PRESET_REAL = 8'h08;
	localparam logic [ADDR_W-1:0] REG_PRESET_LIVE = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_PRESET_IN = 8'h10;
	localparam logic [ADDR_W-1:0] REG_PRESET_OUT = 8'h14;
	localparam logic [ADDR_W-1:0] REG_PRESET_PIX = 8'h18;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h1C;
	localparam logic [ADDR_W-1:0] REG_REAL = 8'h20;
	localparam logic [ADDR_W-1:0] REG_LIVE = 8'h24;
	localparam logic [ADDR_W-1:0] REG_IN = 8'h28;
	localparam logic [ADDR_W-1:0] REG_OUT = 8'h2C;
	localparam logic [ADDR_W-1:0] REG_PIX = 8'h30;
	localparam logic [ADDR_W-1:0] REG_MEM_ADDR = 8'h34;
	localparam logic [ADDR_W-1:0] REG_MEM_DATA = 8'h38;
	localparam logic [ADDR_W-1:0] REG_HOST_DONE = 8'h3C;
	// Control bits
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_MAP = 2;
	localparam int CTRL_PRESERVE = 3;
	localparam int CTRL_EN_REAL = 4;
	localparam int CTRL_EN_LIVE = 5;
	localparam int CTRL_EN_IN = 6;
	localparam int CTRL_EN_OUT = 7;
	localparam int CTRL_EN_PIX = 8;
	localparam int CTRL_PIX_EXT = 9;
	// Status bits
	localparam int ST_RUN = 0;
	localparam int ST_CLEAR = 1;
	localparam int ST_HOST_BANK = 2;
	localparam int ST_SWAP = 3;
	localparam int ST_FULL = 4;
	localparam logic [15:0] NBINS_RESET = 16'h0100;
	typedef enum logic [1:0] {SAM_IDLE, SAM_CLEAR, SAM_RUN} sam_state_t;
endpackage : sam_pkg

// ---- design/sam_fifo.sv ----
// Parameterised valid/ready FIFO
`timescale 1ns/10ps
module sam_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wp_q, wp_d, rp_q, rp_d;
	logic push, pop;
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
	end
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q[PW-1:0]] <= in_data;
		end
	end
	assign in_ready = !((wp_q[PW] != rp_q[PW]) && (wp_q[PW-1:0] == rp_q[PW-1:0]));
	assign out_valid = wp_q != rp_q;
	assign out_data = mem[rp_q[PW-1:0]];
endmodule : sam_fifo

// ---- verification/sam_top_properties.sv ----
// Port-level assertions for the spectrum acquisition memory
`timescale 1ns/10ps
module sam_top_checker (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [sam_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic module_sync_line_o,
	input wire logic module_sync_line_oe,
	input wire logic running
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	AST_RD_IDLE:
	assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its slot");
	AST_UNMAPPED:
	assert property (reg_rd && reg_addr == 8'hFC |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	AST_NBINS:
	assert property (reg_rd && reg_addr == sam_pkg::REG_NBINS
		|=> reg_rdata inside {[32'h100:32'h4000]})
		else $error("bin count out of range");
	AST_START:
	assert property (reg_wr && reg_addr == sam_pkg::REG_CTRL && reg_wdata[0] && !reg_wdata[1]
		|-> ##[1:4] running)
		else $error("start command ignored");
	AST_STOP:
	assert property (reg_wr && reg_addr == sam_pkg::REG_CTRL && reg_wdata[1]
		|-> ##[1:4] !running)
		else $error("stop command ignored");
	AST_SYNC_O:
	assert property (module_sync_line_o == 1'b0)
		else $error("sync line driven high");
	AST_OE_RUN:
	assert property (running && $past(running) |-> !module_sync_line_oe)
		else $error("sync line held low while running");
	AST_SWAP_CLR:
	assert property ((reg_rd && reg_addr == sam_pkg::REG_STATUS) ##1 reg_rdata[sam_pkg::ST_SWAP]
		##1 (reg_rd && reg_addr == sam_pkg::REG_STATUS) |=> !reg_rdata[sam_pkg::ST_SWAP])
		else $error("swap flag not cleared by read");
endmodule : sam_top_checker
bind sam_top sam_top_checker sam_top_checker_inst (
	.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .running(running),
	.module_sync_line_o(module_sync_line_o), .module_sync_line_oe(module_sync_line_oe)
);

// ---- verification/sam_host_model.sv ----
// Host model driving the register port
`timescale 1ns/10ps
module sam_host_model (
	input wire logic clk,
	output logic [sam_pkg::ADDR_W-1:0] reg_addr,
	output logic [31:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [31:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		v = reg_rdata;
	endtask : rd
	task automatic release_bank();
		wr(sam_pkg::REG_HOST_DONE, 32'h1);
	endtask : release_bank
endmodule : sam_host_model

// ---- verification/sam_top_tb.sv ----
// Directed bench for the spectrum acquisition memory
`timescale 1ns/10ps
module sam_top_tb;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	logic core_clk;
	logic reset_n;
	logic [sam_pkg::ADDR_W-1:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic [3:0] evt_valid;
	logic [55:0] evt_energy;
	logic [3:0] evt_seen;
	logic [3:0] live_tick;
	logic gate_in;
	logic ext_logic_in;
	logic pixel_sw;
	logic sync_o;
	logic sync_oe;
	logic sync_line;
	logic [3:0] evt_ready;
	logic running;
	logic [31:0] d;
	logic bank;
	int num_errors;
	int n_checks;
	assign sync_line = !sync_oe;
	sam_top sam_top_inst (
		.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt_valid(evt_valid),
		.evt_energy(evt_energy), .evt_seen(evt_seen), .live_tick(live_tick), .gate_in(gate_in),
		.ext_logic_in(ext_logic_in), .pixel_sw(pixel_sw), .module_sync_line_i(sync_line),
		.module_sync_line_o(sync_o), .module_sync_line_oe(sync_oe), .evt_ready(evt_ready),
		.running(running)
	);
	sam_host_model sam_host_model_inst (
		.clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata)
	);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		sam_host_model_inst.wr(a, v);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, string n);
		sam_host_model_inst.rd(a, d);
		chk(n, e, d & m);
	endtask : rc
	task automatic mem(input logic [15:0] a, input logic [31:0] e);
		wr(sam_pkg::REG_MEM_ADDR, {16'h0, a});
		rc(sam_pkg::REG_MEM_DATA, ALL, e, "bin");
	endtask : mem
	task automatic ev(input int ch, input logic [13:0] e);
		evt_energy[ch*14 +: 14] <= e;
		evt_valid[ch] <= 1'b1;
		@(posedge core_clk);
		evt_valid[ch] <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask : ev
	task automatic pix();
		ext_logic_in <= 1'b1;
		repeat (4) @(posedge core_clk);
		ext_logic_in <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask : pix
	task automatic wait_clear();
		int i;
		i = 0;
		d = ALL;
		while (d[sam_pkg::ST_CLEAR] !== 1'b0 && i < 1000) begin
			sam_host_model_inst.rd(sam_pkg::REG_STATUS, d);
			i++;
		end
		chk("clear done", 32'h0, {31'h0, d[sam_pkg::ST_CLEAR]});
	endtask : wait_clear
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		#1000000;
		num_errors++;
		test_done();
	end
	initial begin
		reset_n = 1'b0;
		evt_valid = 4'h0;
		evt_energy = 56'h0;
		evt_seen = 4'h0;
		live_tick = 4'h0;
		gate_in = 1'b0;
		ext_logic_in = 1'b0;
		pixel_sw = 1'b0;
		num_errors = 0;
		n_checks = 0;
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		rc(sam_pkg::REG_NBINS, ALL, 32'h100, "nbins");
		wr(sam_pkg::REG_NBINS, 32'h10);
		rc(sam_pkg::REG_NBINS, ALL, 32'h100, "nbins low");
		wr(sam_pkg::REG_NBINS, 32'h8000);
		rc(sam_pkg::REG_NBINS, ALL, 32'h4000, "nbins high");
		wr(sam_pkg::REG_NBINS, 32'h100);
		rc(8'hFC, ALL, 32'h0, "unmapped");
		chk("oe idle", 32'h1, {31'h0, sync_oe});
		chk("ready", 32'hF, {28'h0, evt_ready});
		wr(sam_pkg::REG_CTRL, 32'h1);
		wait_clear();
		gate_in <= 1'b1;
		repeat (4) @(posedge core_clk);
		repeat (3) ev(0, 14'h5);
		ev(1, 14'h3FFF);
		gate_in <= 1'b0;
		repeat (4) @(posedge core_clk);
		ev(2, 14'h7);
		gate_in <= 1'b1;
		repeat (10) @(posedge core_clk);
		chk("oe run", 32'h0, {31'h0, sync_oe});
		mem(16'h0005, 32'h3);
		rc(sam_pkg::REG_MEM_DATA, ALL, 32'h0, "next bin");
		mem(16'h40FF, 32'h1);
		mem(16'h8007, 32'h0);
		wr(sam_pkg::REG_CTRL, 32'h2);
		repeat (4) @(posedge core_clk);
		chk("stopped", 32'h0, {31'h0, running});
		mem(16'h0005, 32'h3);
		wr(sam_pkg::REG_PRESET_IN, 32'h2);
		wr(sam_pkg::REG_CTRL, 32'h49);
		repeat (2) begin
			evt_seen <= 4'h1;
			@(posedge core_clk);
			evt_seen <= 4'h0;
			repeat (3) @(posedge core_clk);
		end
		repeat (4) @(posedge core_clk);
		chk("preset stop", 32'h0, {31'h0, running});
		rc(sam_pkg::REG_IN, ALL, 32'h2, "input count");
		mem(16'h0005, 32'h3);
		wr(sam_pkg::REG_PRESET_REAL, 32'h14);
		wr(sam_pkg::REG_CTRL, 32'h19);
		repeat (30) @(posedge core_clk);
		chk("real stop", 32'h0, {31'h0, running});
		rc(sam_pkg::REG_REAL, ALL, 32'h14, "real time");
		wr(sam_pkg::REG_PRESET_LIVE, 32'h4);
		wr(sam_pkg::REG_CTRL, 32'h29);
		repeat (2) begin
			live_tick <= 4'h3;
			@(posedge core_clk);
		end
		live_tick <= 4'h0;
		repeat (4) @(posedge core_clk);
		chk("live stop", 32'h0, {31'h0, running});
		rc(sam_pkg::REG_LIVE, ALL, 32'h4, "live time");
		wr(sam_pkg::REG_PRESET_OUT, 32'h1);
		wr(sam_pkg::REG_CTRL, 32'h89);
		ev(3, 14'h9);
		repeat (4) @(posedge core_clk);
		chk("out stop", 32'h0, {31'h0, running});
		rc(sam_pkg::REG_OUT, ALL, 32'h1, "output count");
		wr(sam_pkg::REG_PRESET_PIX, 32'h3);
		wr(sam_pkg::REG_CTRL, 32'h30D);
		wait_clear();
		pixel_sw <= 1'b1;
		repeat (4) @(posedge core_clk);
		pixel_sw <= 1'b0;
		repeat (4) @(posedge core_clk);
		rc(sam_pkg::REG_PIX, ALL, 32'h0, "pixel source");
		sam_host_model_inst.rd(sam_pkg::REG_STATUS, d);
		bank = d[sam_pkg::ST_HOST_BANK];
		pix();
		rc(sam_pkg::REG_STATUS, 32'h8, 32'h0, "early swap");
		sam_host_model_inst.release_bank();
		pix();
		rc(sam_pkg::REG_STATUS, 32'hC, {28'h0, 1'b1, !bank, 2'h0}, "swap");
		rc(sam_pkg::REG_STATUS, 32'h8, 32'h0, "swap cleared");
		pix();
		chk("pixel stop", 32'h0, {31'h0, running});
		rc(sam_pkg::REG_PIX, ALL, 32'h3, "pixels");
		test_done();
	end
endmodule : sam_top_tb
